/* lcd_pkg.sv */
// constants shared by the segment shift/latch driver and its fifo
// assumes nothing beyond a systemverilog compiler
package lcd_pkg;
    localparam int SEG_COUNT = 31;
    localparam int FIFO_DEPTH = 16;
    localparam logic [30:0] SEG_RESET = 31'h0000_0000;
    localparam logic LOAD_RESET = 1'b0;
    localparam logic PLANE_RESET = 1'b0;
endpackage : lcd_pkg

/* lcd_segment_shift_latch.sv */
// serial-in static lcd segment driver: link-clocked shift path, fifo, latches
// assumes sclk_i from the controller, far slower than clk_i (>= 8 clk periods)

module seg_fifo #(
    parameter int WIDTH = 31,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        push = in_valid_i && (cnt_q != (AW+1)'(DEPTH));
        pop = out_ready_i && (cnt_q != '0);
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage needs no reset; reads are gated by the count
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];

    // the level can never pass the depth, else the pointers alias
    AST_FIFO_BOUND: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cnt_q <= (AW+1)'(DEPTH))
        else $error("fifo level above its depth");

    // a word accepted while nothing drains must show up at the far side
    AST_FIFO_SHOW: assert property (@(posedge clk_i) disable iff (!nrst_i)
        in_valid_i && in_ready_o && !out_ready_i |=> out_valid_o)
        else $error("accepted word not visible at the drain side");

    // an empty queue with nothing offered stays empty
    AST_FIFO_EMPTY: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !out_valid_o && !in_valid_i |=> !out_valid_o)
        else $error("empty fifo produced a word from nowhere");

    // the queue may refuse a word only while it is full
    AST_FIFO_FULL: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !in_ready_o |-> cnt_q == (AW+1)'(DEPTH))
        else $error("fifo refused a word while not full");
endmodule : seg_fifo

module lcd_segment_shift_latch #(
    parameter int SEGS = lcd_pkg::SEG_COUNT,
    parameter int DEPTH = lcd_pkg::FIFO_DEPTH
) (
    // system clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // serial link from the controller
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic load_i,
    output logic sdata_o,
    // display drive
    input wire logic common_plane_input_i,
    output logic common_plane_output_o,
    output logic [SEGS-1:0] segment_o,
    // status
    output logic overflow_o
);
    // ---------------- link domain ----------------
    logic lrst_s1_q, lrst_n_q;
    logic [SEGS-1:0] shift_q, shift_d;
    logic tog_q, tog_d;

    // reset reaches the link side through its own synchroniser
    always_ff @(posedge sclk_i) begin
        lrst_s1_q <= nrst_i;
        lrst_n_q <= lrst_s1_q;
    end

    always_comb begin
        shift_d = {shift_q[SEGS-2:0], sdata_i};
        tog_d = ~tog_q;
    end

    always_ff @(posedge sclk_i) begin
        if (!lrst_n_q) begin
            shift_q <= lcd_pkg::SEG_RESET[SEGS-1:0];
            tog_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            tog_q <= tog_d;
        end
    end

    assign sdata_o = shift_q[SEGS-1];

    AST_CASCADE: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
        $past(lrst_n_q, 32) |-> sdata_o == $past(sdata_i, SEGS))
        else $error("serial out is not data delayed by the stage count");

    AST_SHIFT: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
        $past(lrst_n_q) |-> shift_q[SEGS-1:1] == $past(shift_q[SEGS-2:0]))
        else $error("shift path did not advance by one stage");

    // the newest stage always holds the data level taken at the edge
    AST_STAGE0: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
        $past(lrst_n_q) |-> shift_q[0] == $past(sdata_i))
        else $error("stage zero did not take the data pin");

    // a link reset clears every stage, so no stale pattern is cascaded
    AST_LINK_RST: assert property (@(posedge sclk_i)
        !lrst_n_q |=> shift_q == '0)
        else $error("link reset did not clear the shift path");

    // ---------------- system domain ----------------
    logic tog_s1_q, tog_s2_q, tog_s3_q;
    logic load_s1_q, load_s_q;
    logic bp_s1_q, bp_s_q;
    logic shift_ev;
    logic f_in_ready, f_out_valid, f_out_ready;
    logic [SEGS-1:0] f_out_data;
    logic pace_q, pace_d;
    logic [SEGS-1:0] mirror_q, mirror_d;
    logic [SEGS-1:0] latch_q, latch_d;
    logic [SEGS-1:0] seg_q, seg_d;
    logic common_plane_output_q, common_plane_output_d;
    logic ovf_q, ovf_d;

    // pin levels and the shift toggle pass two flops before use
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
            load_s1_q <= lcd_pkg::LOAD_RESET;
            load_s_q <= lcd_pkg::LOAD_RESET;
            bp_s1_q <= lcd_pkg::PLANE_RESET;
            bp_s_q <= lcd_pkg::PLANE_RESET;
        end else begin
            tog_s1_q <= tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
            load_s1_q <= load_i;
            load_s_q <= load_s1_q;
            bp_s1_q <= common_plane_input_i;
            bp_s_q <= bp_s1_q;
        end
    end

    // the shift word is only sampled after its toggle has settled; it then
    // stays still for the rest of the link period, which must outlast the sync
    assign shift_ev = tog_s2_q ^ tog_s3_q;

    seg_fifo #(
        .WIDTH(SEGS),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(shift_ev),
        .in_ready_o(f_in_ready),
        .in_data_i(shift_q),
        .out_valid_o(f_out_valid),
        .out_ready_i(f_out_ready),
        .out_data_o(f_out_data)
    );

    // drain paces at one word per two cycles, so bursts really queue up
    assign f_out_ready = pace_q;

    always_comb begin
        pace_d = ~pace_q;
        mirror_d = (f_out_valid && f_out_ready) ? f_out_data : mirror_q;
        // load level opens the latches; sclk plays no part in it
        latch_d = load_s_q ? mirror_d : latch_q;
        seg_d = latch_q ^ {SEGS{bp_s_q}};
        common_plane_output_d = bp_s_q;
        // a dropped shift word is a lost display bit: sticky until reset
        ovf_d = ovf_q || (shift_ev && !f_in_ready);
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pace_q <= 1'b0;
            mirror_q <= lcd_pkg::SEG_RESET[SEGS-1:0];
            latch_q <= lcd_pkg::SEG_RESET[SEGS-1:0];
            seg_q <= lcd_pkg::SEG_RESET[SEGS-1:0];
            common_plane_output_q <= lcd_pkg::PLANE_RESET;
            ovf_q <= 1'b0;
        end else begin
            pace_q <= pace_d;
            mirror_q <= mirror_d;
            latch_q <= latch_d;
            seg_q <= seg_d;
            common_plane_output_q <= common_plane_output_d;
            ovf_q <= ovf_d;
        end
    end

    assign segment_o = seg_q;
    assign common_plane_output_o = common_plane_output_q;
    assign overflow_o = ovf_q;

    AST_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !load_s_q ##1 (!load_s_q && $stable(bp_s_q)) |=> $stable(segment_o))
        else $error("segment outputs moved while load was low");

    AST_TRANSP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        load_s_q && f_out_valid && f_out_ready |=> latch_q == $past(f_out_data))
        else $error("open latch did not take the shifted word");

    AST_FOLLOW: assert property (@(posedge clk_i) disable iff (!nrst_i)
        load_s_q |=> ##1 segment_o == ($past(mirror_q) ^ {SEGS{$past(bp_s_q)}}))
        else $error("latches do not follow the shift path with load high");

    AST_PHASE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $past(nrst_i) |-> segment_o == ($past(latch_q) ^ {SEGS{$past(bp_s_q)}}))
        else $error("segment phase does not match latch and plane");

    AST_DRAIN: assert property (@(posedge clk_i) disable iff (!nrst_i)
        f_out_valid |-> ##[0:1] (f_out_valid && f_out_ready))
        else $error("queued shift word not drained within two cycles");

    AST_PLANE_OUT: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $past(nrst_i) |-> common_plane_output_o == $past(bp_s_q))
        else $error("plane output does not follow the plane input");

    // the drain outruns the legal shift rate, so nothing is ever dropped
    AST_NO_DROP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        shift_ev |-> f_in_ready)
        else $error("shift word offered to a full fifo");

    AST_OVF_STICKY: assert property (@(posedge clk_i) disable iff (!nrst_i)
        overflow_o |=> overflow_o)
        else $error("overflow flag cleared without reset");

    // closed latches ignore all shifting and draining
    AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !load_s_q |=> $stable(latch_q))
        else $error("latch moved while load was low");

    AST_MIRROR: assert property (@(posedge clk_i) disable iff (!nrst_i)
        f_out_valid && f_out_ready |=> mirror_q == $past(f_out_data))
        else $error("drained word not copied into the mirror");

    // one toggle per link edge; edges closer than the sync would merge
    AST_ONE_EVENT: assert property (@(posedge clk_i) disable iff (!nrst_i)
        shift_ev |=> !shift_ev)
        else $error("two shift events in consecutive cycles");

    // reset blanks the display and clears the flag in the next cycle
    AST_SEG_RESET: assert property (@(posedge clk_i)
        !nrst_i |=> (segment_o == '0) && !overflow_o)
        else $error("reset did not blank the segment outputs");

endmodule : lcd_segment_shift_latch

/* lcd_ctrl_model.sv */
// controller model: drives serial clock, data and load of the shift latch
// assumes clk_i is the system clock; every change lands on its falling edge
module lcd_ctrl_model (
    input wire logic clk_i,
    output logic sclk_o,
    output logic sdata_o,
    output logic load_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        load_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    // msb first; sclk stands low between frames, data is spoiled after the frame
    task automatic shift_word(input logic [30:0] w, input int n, input int half);
        for (int i = 30; i > 30 - n; i--) begin
            sdata_o = w[i];
            tick(half);
            sclk_o = 1'b1;
            tick(half);
            sclk_o = 1'b0;
        end
        sdata_o = ~sdata_o;
    endtask : shift_word
    // waits for the fifo to drain so the latest word is the one latched
    task automatic pulse_load();
        tick(32);
        load_o = 1'b1;
        tick(100);
        load_o = 1'b0;
    endtask : pulse_load
    task automatic set_load(input logic v);
        load_o = v;
    endtask : set_load
endmodule : lcd_ctrl_model

/* lcd_segment_shift_latch_tb_top.sv */
// self-checking bench for the segment shift/latch driver
// assumes lcd_ctrl_model drives the serial link
module lcd_segment_shift_latch_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic plane = 1'b0;
    logic sclk, sdata, load, sdata_o, plane_o, overflow_o;
    logic [30:0] seg;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    typedef struct {logic [30:0] w; logic p;} row_s;
    row_s rows [4] = '{'{31'h0000_0001, 1'b0}, '{31'h4000_0000, 1'b0},
        '{31'h2AAA_AAAA, 1'b1}, '{31'h7FFF_FFFF, 1'b1}};
    always #2.5 clk_i = ~clk_i;
    lcd_ctrl_model i_lcd_ctrl_model (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata),
        .load_o(load));
    lcd_segment_shift_latch i_lcd_segment_shift_latch (.clk_i(clk_i), .nrst_i(nrst_i),
        .sclk_i(sclk), .sdata_i(sdata), .load_i(load), .sdata_o(sdata_o),
        .common_plane_input_i(plane), .common_plane_output_o(plane_o),
        .segment_o(seg), .overflow_o(overflow_o));
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk_seg(input logic [30:0] e);
        num_checks++;
        if (seg !== e) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, seg, e);
        end
    endtask : chk_seg
    task automatic chk_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_bit
    // a hung wait ends here instead of running forever
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        // the link side needs sclk edges while reset is held
        i_lcd_ctrl_model.shift_word(31'h0000_0000, 3, 8);
        nrst_i = 1'b1;
        i_lcd_ctrl_model.shift_word(31'h0000_0000, 2, 8);
        foreach (rows[i]) begin
            plane = rows[i].p;
            i_lcd_ctrl_model.shift_word(rows[i].w, 31, 8);
            chk_bit(sdata_o, rows[i].w[30]);
            i_lcd_ctrl_model.pulse_load();
            repeat (8) @(negedge clk_i);
            chk_seg(rows[i].w ^ {31{rows[i].p}});
            chk_bit(plane_o, rows[i].p);
            $display("row %0d done", i);
        end
        plane = 1'b0;
        i_lcd_ctrl_model.shift_word(31'h1234_5678, 31, 8);
        repeat (40) @(negedge clk_i);
        chk_seg(31'h7FFF_FFFF);
        $display("hold done");
        // load held high: one slow shift shows at once on the segments
        i_lcd_ctrl_model.set_load(1'b1);
        i_lcd_ctrl_model.shift_word(31'h4000_0000, 1, 20);
        chk_seg(31'h2468_ACF1);
        i_lcd_ctrl_model.set_load(1'b0);
        $display("two-wire done");
        plane = 1'b1;
        nrst_i = 1'b0;
        i_lcd_ctrl_model.shift_word(31'h0000_0000, 3, 8);
        chk_seg(31'h0000_0000);
        chk_bit(plane_o, 1'b0);
        chk_bit(overflow_o, 1'b0);
        nrst_i = 1'b1;
        repeat (6) @(negedge clk_i);
        chk_bit(plane_o, 1'b1);
        chk_seg(31'h7FFF_FFFF);
        $display("reset done");
        end_sim();
    end
endmodule : lcd_segment_shift_latch_tb_top
